//--- can_peer.sv
`timescale 1ns/10ps
// Far-side nodes as seen by this block: bit timing and bus level
module can_peer (
   input  wire logic mclk,        // System clock
   output logic      bit_tick,    // Bit-time pulse
   output logic      rx_dominant  // Bus level, 1 = dominant
);
   // Bus rests recessive between bits, as the real line does
   initial begin
      bit_tick = 1'b0;
      rx_dominant = 1'b0;
   end
   // Sends n bits of one level; holds nothing once a bit has passed
   task automatic bits(input int n, input logic dom);
      repeat (n) begin
         @(posedge mclk);
         bit_tick <= 1'b1;
         rx_dominant <= dom;
         @(posedge mclk);
         bit_tick <= 1'b0;
         rx_dominant <= 1'b0;
      end
   endtask
endmodule

//--- fault_confine.sv
// Behaviour
// [RULE1] Receiver error adds one to receive count, except bit error in active flag.
// [RULE2] Dominant first bit after own error flag adds eight to receive count.
// [RULE3] Transmitter sending an error flag adds eight to transmit count.
// [RULE4] Passive ack error with no dominant in passive flag leaves transmit count.
// [RULE5] Stuff error in arbitration before remote bit leaves transmit count.
// [RULE6] Transmitter bit error during active or overload flag adds eight.
// [RULE7] Receiver bit error during active or overload flag adds eight.
// [RULE8] After flags, 14th or 8th dominant bit and each eight more add eight.
// [RULE9] Successful transmission subtracts one from transmit count, floor zero.
// [RULE10] Successful reception: decrement, hold zero, or reload 119 above 127.
// [RULE11] Passive node returns active when both counts are at most 127.
// [RULE12] Bus-off ends after 128 runs of 11 recessive bits, counts cleared.
// [RULE13] Remote write frame: byte one low bits select register, byte two data.
// [RULE14] Each sent frame's first byte holds status and register selector.
// [RULE15] Warning bit set once a count reached 32 since last good message.
// [RULE16] Status bits 5..4 give bus mode, bit 3 zero, bits 2..0 selector.
// [RULE17] First frame after reset carries reset indicator one, later frames zero.
// [RULE18] Either count at 128 or more makes node passive, passive flags only.
// [RULE19] Transmit count 256 or more means bus-off with drivers switched off.
`timescale 1ns/10ps
module fault_confine
   import fc_pkg::*;
(
   input  wire logic        mclk,           // 50 MHz clock
   input  wire logic        reset_n,        // Synchronous reset
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB enable
   input  wire logic        pwrite,         // APB direction
   input  wire logic [11:0] paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   output logic [31:0]      prdata,         // APB read data
   output logic             pready,         // APB ready
   output logic             pslverr,        // APB error, unmapped
   input  wire logic        bit_tick,       // Bit-time enable
   input  wire logic        rx_dominant,    // Sampled bus level
   input  wire logic        is_transmitter, // Node owns the frame
   input  wire logic        rx_err,         // Receiver detected error
   input  wire logic        flag_bit_err,   // Bit error in active/overload flag
   input  wire logic        tx_flag,        // Transmitter sends error flag
   input  wire logic        exc_ack_nodom,  // Ack error, no dominant in flag
   input  wire logic        exc_stuff_arb,  // Stuff error in arbitration
   input  wire logic        dom_after_flag, // Dominant first bit after flag
   input  wire logic        flag_done,      // Own flag finished
   input  wire logic        flag_passive,   // Finished flag was passive
   input  wire logic        tx_ok,          // Transmission succeeded
   input  wire logic        rx_ok,          // Reception succeeded
   input  wire logic [1:0]  bus_mode,       // Current bus mode
   input  wire logic [2:0]  reg_sel,        // Selector for sent frame
   input  wire logic        rx_frame_wr,    // Write frame received
   input  wire logic [7:0]  rx_byte_one,    // Received first byte
   input  wire logic [7:0]  rx_byte_two,    // Received second byte
   output logic             passive_only,   // Send passive flags only
   output logic             bus_off,        // Node is bus-off
   output logic             drivers_en,     // Line drivers enabled
   output logic             error_warning_bit, // Warning status bit
   output logic [7:0]       status_byte,    // First byte of sent frames
   output logic             port_wr,        // Register write pulse
   output logic [2:0]       port_sel,       // Register written
   output logic [7:0]       port_data       // Value written
);

   fc_state_t  state_reg;
   fc_state_t  state_next;
   logic [8:0] tec_reg;
   logic [8:0] tec_next;
   logic [8:0] rec_reg;
   logic [8:0] rec_next;
   logic       recovered;
   logic       tx_exempt;
   logic       dom_fire;
   logic [4:0] dom_cnt_reg;
   logic [4:0] dom_cnt_next;
   logic [4:0] dom_lim_reg;
   logic [4:0] dom_lim_next;
   logic       dom_act_reg;
   logic       dom_act_next;
   logic       ctrl_en_reg;
   logic       ctrl_en_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic       ready_reg;
   logic       ready_next;
   logic       err_reg;
   logic       err_next;
   logic       port_wr_reg;
   logic [2:0] port_sel_reg;
   logic [7:0] port_data_reg;
   logic       addr_ok;
   logic       passive_reg;
   logic       passive_next;
   logic       drv_reg;
   logic       drv_next;

   // Both exceptions keep the transmit count unchanged
   assign tx_exempt = exc_stuff_arb                                      // see [RULE5]
                    | (exc_ack_nodom && state_reg == ERR_PASSIVE);       // see [RULE4]

   // Error counters and confinement state
   always_comb begin
      tec_next = tec_reg;
      rec_next = rec_reg;
      if (tx_ok && tec_reg != CNT_ZERO)
         tec_next = tec_reg - INC_ONE;                                   // see [RULE9]
      if (rx_ok) begin
         if (rec_reg > PASSIVE_MAX)
            rec_next = REC_RELOAD;                                       // see [RULE10]
         else if (rec_reg != CNT_ZERO)
            rec_next = rec_reg - INC_ONE;
      end
      if (tx_flag && !tx_exempt)
         tec_next = sat_add(tec_next, INC_EIGHT);                        // see [RULE3]
      if (flag_bit_err && is_transmitter)
         tec_next = sat_add(tec_next, INC_EIGHT);                        // see [RULE6]
      if (flag_bit_err && !is_transmitter)
         rec_next = sat_add(rec_next, INC_EIGHT);                        // see [RULE7]
      if (rx_err && !flag_bit_err)
         rec_next = sat_add(rec_next, INC_ONE);                          // see [RULE1]
      if (dom_after_flag && !is_transmitter)
         rec_next = sat_add(rec_next, INC_EIGHT);                        // see [RULE2]
      if (dom_fire && is_transmitter)
         tec_next = sat_add(tec_next, INC_EIGHT);                        // see [RULE8]
      if (dom_fire && !is_transmitter)
         rec_next = sat_add(rec_next, INC_EIGHT);                        // see [RULE8]
      state_next = state_reg;
      unique case (state_reg)
         BUS_OFF: begin
            // Frozen counts: a bus-off node takes no part in frames
            tec_next = tec_reg;
            rec_next = rec_reg;
            if (recovered) begin
               tec_next = CNT_ZERO;                                      // see [RULE12]
               rec_next = CNT_ZERO;
               state_next = ERR_ACTIVE;
            end
         end
         ERR_ACTIVE, ERR_PASSIVE: begin
            if (tec_next >= BUSOFF_LIM)
               state_next = BUS_OFF;                                     // see [RULE19]
            else if (tec_next >= PASSIVE_LIM || rec_next >= PASSIVE_LIM)
               state_next = ERR_PASSIVE;                                 // see [RULE18]
            else
               state_next = ERR_ACTIVE;                                  // see [RULE11]
         end
         default: begin
            state_next = BUS_OFF;
         end
      endcase
      passive_next = state_next == ERR_PASSIVE;                          // see [RULE18]
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_reg <= ERR_ACTIVE;
         tec_reg <= CNT_ZERO;
         rec_reg <= CNT_ZERO;
         passive_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tec_reg <= tec_next;
         rec_reg <= rec_next;
         passive_reg <= passive_next;
      end
   end

   // Dominant run after a flag; fires at limit, then every eight bits
   always_comb begin
      dom_cnt_next = dom_cnt_reg;
      dom_lim_next = dom_lim_reg;
      dom_act_next = dom_act_reg;
      dom_fire = 1'b0;
      if (flag_done) begin
         dom_act_next = 1'b1;
         dom_cnt_next = DOM_ZERO;
         dom_lim_next = flag_passive ? DOM_LIM_PAS : DOM_LIM_ACT;
      end else if (dom_act_reg && bit_tick) begin
         if (!rx_dominant) begin
            dom_act_next = 1'b0;
         end else if (dom_cnt_reg + DOM_ONE == dom_lim_reg) begin
            dom_fire = 1'b1;                                             // see [RULE8]
            dom_cnt_next = dom_lim_reg - DOM_STEP;
         end else begin
            dom_cnt_next = dom_cnt_reg + DOM_ONE;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         dom_cnt_reg <= DOM_ZERO;
         dom_lim_reg <= DOM_LIM_ACT;
         dom_act_reg <= 1'b0;
      end else begin
         dom_cnt_reg <= dom_cnt_next;
         dom_lim_reg <= dom_lim_next;
         dom_act_reg <= dom_act_next;
      end
   end

   // Recessive run tally, active only while bus-off
   recessive_run u_run (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .enable       (state_reg == BUS_OFF),
      .bit_tick     (bit_tick),
      .rx_recessive (!rx_dominant),
      .recovered    (recovered)
   );

   // Status byte and warning flag
   status_byte_gen u_status (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .warn_cond   (tec_reg >= WARN_LIM || rec_reg >= WARN_LIM),
      .msg_ok      (tx_ok || rx_ok),
      .sent_ok     (tx_ok),
      .bus_mode    (bus_mode),
      .reg_sel     (reg_sel),
      .status_byte (status_byte),
      .warn_bit    (error_warning_bit)
   );

   // APB slave: data staged in setup so access completes in one cycle
   assign addr_ok = paddr == ADDR_CTRL || paddr == ADDR_COUNT || paddr == ADDR_STATUS;

   always_comb begin
      ctrl_en_next = ctrl_en_reg;
      ready_next = psel && !penable;
      err_next = psel && !penable && !addr_ok;
      rdata_next = RD_ZERO;
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            ADDR_CTRL:   rdata_next = {31'h0000_0000, ctrl_en_reg};
            ADDR_COUNT:  rdata_next = {7'h00, rec_reg, 7'h00, tec_reg};
            ADDR_STATUS: rdata_next = {22'h00_0000, state_reg, status_byte};
            default:     rdata_next = RD_ZERO;
         endcase
      end
      if (psel && penable && ready_reg && pwrite && paddr == ADDR_CTRL)
         ctrl_en_next = pwdata[0];
      drv_next = ctrl_en_next && state_next != BUS_OFF;                 // see [RULE19]
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ctrl_en_reg <= CTRL_RESET;
         drv_reg <= CTRL_RESET;
         rdata_reg <= RD_ZERO;
         ready_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         ctrl_en_reg <= ctrl_en_next;
         drv_reg <= drv_next;
         rdata_reg <= rdata_next;
         ready_reg <= ready_next;
         err_reg <= err_next;
      end
   end

   // Remote register writes; reserved upper bits of byte one dropped
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         port_wr_reg <= 1'b0;
         port_sel_reg <= 3'h0;
         port_data_reg <= 8'h00;
      end else begin
         port_wr_reg <= rx_frame_wr;                                     // see [RULE13]
         if (rx_frame_wr) begin
            port_sel_reg <= rx_byte_one[2:0];
            port_data_reg <= rx_byte_two;
         end
      end
   end

   assign prdata = rdata_reg;
   assign pready = ready_reg;
   assign pslverr = err_reg;
   // Flop-driven outputs; only bus-off has the upper state bit set
   assign passive_only = passive_reg;
   assign bus_off = state_reg[1];
   assign drivers_en = drv_reg;
   assign port_wr = port_wr_reg;
   assign port_sel = port_sel_reg;
   assign port_data = port_data_reg;

   // Checks
   tec_dec_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tx_ok && tec_reg != CNT_ZERO && !tx_flag && !flag_bit_err && !dom_fire && state_reg != BUS_OFF
      |=> tec_reg == $past(tec_reg) - INC_ONE) else $error("transmit count not decremented"); // see [RULE9]
   rec_reload_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rx_ok && rec_reg > PASSIVE_MAX && !rx_err && !flag_bit_err && !dom_after_flag && !dom_fire
      && state_reg != BUS_OFF |=> rec_reg == REC_RELOAD) else $error("receive count not reloaded"); // see [RULE10]
   rec_one_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rx_err && !flag_bit_err && !dom_after_flag && !dom_fire && !rx_ok && rec_reg < PASSIVE_LIM
      && state_reg != BUS_OFF |=> rec_reg == $past(rec_reg) + INC_ONE) else $error("receive error not counted"); // see [RULE1]
   rec_dom_a: assert property (@(posedge mclk) disable iff (!reset_n)
      dom_after_flag && !is_transmitter && !rx_err && !flag_bit_err && !dom_fire && !rx_ok
      && rec_reg < PASSIVE_LIM && state_reg != BUS_OFF
      |=> rec_reg == $past(rec_reg) + INC_EIGHT) else $error("dominant after flag not counted"); // see [RULE2]
   tec_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tx_flag && !exc_stuff_arb && !exc_ack_nodom && !flag_bit_err && !dom_fire && !tx_ok
      && tec_reg < BUSOFF_LIM |=> tec_reg == $past(tec_reg) + INC_EIGHT) else $error("error flag not counted"); // see [RULE3]
   tec_stuff_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tx_flag && exc_stuff_arb && !flag_bit_err && !dom_fire && !tx_ok
      |=> $stable(tec_reg)) else $error("stuff exception changed count"); // see [RULE5]
   tec_ack_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tx_flag && exc_ack_nodom && passive_only && !flag_bit_err && !dom_fire && !tx_ok
      |=> $stable(tec_reg)) else $error("ack exception changed count"); // see [RULE4]
   busoff_out_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tec_reg >= BUSOFF_LIM |-> bus_off && !drivers_en) else $error("bus-off not shown"); // see [RULE19]
   passive_lvl_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !bus_off |-> passive_only == (tec_reg >= PASSIVE_LIM || rec_reg >= PASSIVE_LIM))
      else $error("passive state wrong"); // see [RULE18]
   recover_a: assert property (@(posedge mclk) disable iff (!reset_n)
      bus_off && recovered |=> tec_reg == CNT_ZERO && rec_reg == CNT_ZERO && !bus_off)
      else $error("bus-off recovery wrong"); // see [RULE12]
   warn_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tec_reg >= WARN_LIM || rec_reg >= WARN_LIM |=> error_warning_bit) else $error("warning not set"); // see [RULE15]
   status_fmt_a: assert property (@(posedge mclk) disable iff (!reset_n)
      reset_n |=> status_byte[SB_RSVD] == SB_RSVD_VAL && status_byte[5:4] == $past(bus_mode))
      else $error("status byte layout wrong"); // see [RULE16]
   c_recover: cover property (@(posedge mclk) disable iff (!reset_n) bus_off && recovered);
   c_passive: cover property (@(posedge mclk) disable iff (!reset_n) $rose(passive_only));
   c_domfire: cover property (@(posedge mclk) disable iff (!reset_n) dom_fire);
   c_reload:  cover property (@(posedge mclk) disable iff (!reset_n) rx_ok && rec_reg > PASSIVE_MAX);

endmodule

//--- fault_confine_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module fault_confine_tb_top;
   import fc_pkg::*;
   logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, serr, bit_tick, rx_dominant;
   logic        is_tx, exc_ack, exc_stuff, flag_pas, passive_only, bus_off, drivers_en, warn, port_wr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  ev, b1, b2, status_byte, port_data;
   logic [1:0]  bus_mode;
   logic [2:0]  reg_sel, port_sel;
   int          fails, num_checks;

   fault_confine i_fault_confine (
      .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_tick(bit_tick),
      .rx_dominant(rx_dominant), .is_transmitter(is_tx), .rx_err(ev[0]), .flag_bit_err(ev[1]), .tx_flag(ev[2]),
      .exc_ack_nodom(exc_ack), .exc_stuff_arb(exc_stuff), .dom_after_flag(ev[3]), .flag_done(ev[4]),
      .flag_passive(flag_pas), .tx_ok(ev[5]), .rx_ok(ev[6]), .bus_mode(bus_mode), .reg_sel(reg_sel),
      .rx_frame_wr(ev[7]), .rx_byte_one(b1), .rx_byte_two(b2), .passive_only(passive_only), .bus_off(bus_off),
      .drivers_en(drivers_en), .error_warning_bit(warn), .status_byte(status_byte), .port_wr(port_wr),
      .port_sel(port_sel), .port_data(port_data));
   can_peer i_can_peer (.mclk(mclk), .bit_tick(bit_tick), .rx_dominant(rx_dominant));

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Event pulses one cycle each, then time for counts and status to land
   task automatic fire(input logic [7:0] m, input int n = 1);
      repeat (n) begin
         @(posedge mclk);
         ev <= m;
         @(posedge mclk);
         ev <= 8'h00;
      end
      tick(2);
   endtask
   // APB transfer; waits on pready, never on a fixed count
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         wrap_up();
      end
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, e)
   endtask
   task automatic cnt(input logic [8:0] tec, input logic [8:0] rec);
      rchk(ADDR_COUNT, {7'h00, rec, 7'h00, tec});
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard, several times the expected run length
   initial begin
      #400000;
      fails++;
      wrap_up();
   end

   // Test sequence
   initial begin
      {psel, penable, pwrite, is_tx, exc_ack, exc_stuff, flag_pas} = '0;
      {paddr, pwdata, ev, b1, b2} = '0;
      bus_mode = 2'b10;
      reg_sel = 3'h5;
      fails = 0;
      num_checks = 0;
      reset_n = 1'b0;
      tick(6);
      reset_n <= 1'b1;
      rchk(ADDR_CTRL, 32'h0000_0001);
      rchk(ADDR_STATUS, 32'h0000_00a5);
      rchk(12'h00c, 32'h0000_0000);
      `CHK(serr, 1'b1)
      apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      // Output settles after the access edge; look mid-cycle
      @(negedge mclk);
      `CHK(drivers_en, 1'b0)
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      apb(1'b1, ADDR_COUNT, 32'hffff_ffff);
      fire(8'h40);
      cnt(9'h000, 9'h000);
      $display("test reset done");
      fire(8'h01);
      cnt(9'h000, 9'h001);
      fire(8'h02);
      cnt(9'h000, 9'h009);
      fire(8'h08);
      cnt(9'h000, 9'h011);
      is_tx <= 1'b1;
      fire(8'h04);
      cnt(9'h008, 9'h011);
      exc_stuff <= 1'b1;
      fire(8'h04);
      cnt(9'h008, 9'h011);
      exc_stuff <= 1'b0;
      fire(8'h02);
      cnt(9'h010, 9'h011);
      fire(8'h20);
      cnt(9'h00f, 9'h011);
      `CHK(status_byte, 8'h25)
      for (int m = 0; m < 3; m++) begin
         bus_mode <= m[1:0];
         reg_sel <= 3'(m * 3);
         tick(3);
         `CHK(status_byte, {2'b00, m[1:0], 1'b0, 3'(m * 3)})
      end
      fire(8'h40);
      cnt(9'h00f, 9'h010);
      $display("test counters done");
      fire(8'h10);
      i_can_peer.bits(13, 1'b1);
      cnt(9'h00f, 9'h010);
      i_can_peer.bits(1, 1'b1);
      tick(2);
      cnt(9'h017, 9'h010);
      i_can_peer.bits(8, 1'b1);
      tick(2);
      cnt(9'h01f, 9'h010);
      `CHK(warn, 1'b0)
      i_can_peer.bits(1, 1'b0);
      flag_pas <= 1'b1;
      fire(8'h10);
      i_can_peer.bits(8, 1'b1);
      tick(3);
      cnt(9'h027, 9'h010);
      `CHK(warn, 1'b1)
      i_can_peer.bits(1, 1'b0);
      flag_pas <= 1'b0;
      $display("test dominant runs done");
      fire(8'h04, 11);
      `CHK(passive_only, 1'b0)
      fire(8'h04);
      `CHK(passive_only, 1'b1)
      exc_ack <= 1'b1;
      fire(8'h04);
      cnt(9'h087, 9'h010);
      exc_ack <= 1'b0;
      fire(8'h20, 8);
      cnt(9'h07f, 9'h010);
      `CHK(passive_only, 1'b0)
      is_tx <= 1'b0;
      fire(8'h08, 15);
      `CHK(passive_only, 1'b1)
      fire(8'h40);
      cnt(9'h07f, 9'h077);
      `CHK(passive_only, 1'b0)
      $display("test passive done");
      is_tx <= 1'b1;
      fire(8'h04, 16);
      `CHK(bus_off, 1'b0)
      fire(8'h04);
      `CHK(bus_off, 1'b1)
      `CHK(drivers_en, 1'b0)
      fire(8'h01);
      cnt(9'h107, 9'h077);
      i_can_peer.bits(1407, 1'b0);
      tick(3);
      `CHK(bus_off, 1'b1)
      i_can_peer.bits(1, 1'b0);
      tick(3);
      `CHK(bus_off, 1'b0)
      `CHK(drivers_en, 1'b1)
      cnt(9'h000, 9'h000);
      $display("test bus-off done");
      b1 <= 8'hfb;
      b2 <= 8'h5a;
      @(posedge mclk);
      ev <= 8'h80;
      @(posedge mclk);
      ev <= 8'h00;
      // Write pulse stands one cycle; sample it mid-cycle, not at its edges
      @(negedge mclk);
      `CHK({port_wr, port_sel, port_data}, {1'b1, 3'h3, 8'h5a})
      @(negedge mclk);
      `CHK(port_wr, 1'b0)
      $display("test remote write done");
      wrap_up();
   end
endmodule

//--- fc_pkg.sv
package fc_pkg;

   // Counter widths and limits
   localparam logic [8:0]  CNT_ZERO    = 9'h000;
   localparam logic [8:0]  CNT_MAX     = 9'h1ff;
   localparam logic [8:0]  INC_ONE     = 9'h001;
   localparam logic [8:0]  INC_EIGHT   = 9'h008;
   localparam logic [8:0]  WARN_LIM    = 9'h020;
   localparam logic [8:0]  PASSIVE_MAX = 9'h07f;
   localparam logic [8:0]  PASSIVE_LIM = 9'h080;
   localparam logic [8:0]  BUSOFF_LIM  = 9'h100;
   localparam logic [8:0]  REC_RELOAD  = 9'h077;

   // Dominant bits tolerated after a flag
   localparam logic [4:0]  DOM_LIM_ACT = 5'h0e;
   localparam logic [4:0]  DOM_LIM_PAS = 5'h08;
   localparam logic [4:0]  DOM_STEP    = 5'h08;
   localparam logic [4:0]  DOM_ZERO    = 5'h00;
   localparam logic [4:0]  DOM_ONE     = 5'h01;

   // Bus-off recovery: 128 runs of 11 recessive bits
   localparam logic [3:0]  RUN_LAST    = 4'ha;
   localparam logic [6:0]  OCC_LAST    = 7'h7f;

   // Status byte fields
   localparam int unsigned SB_RSTD     = 7;
   localparam int unsigned SB_WARN     = 6;
   localparam int unsigned SB_MODE_LO  = 4;
   localparam int unsigned SB_RSVD     = 3;
   localparam logic        SB_RSVD_VAL = 1'b0;

   // APB register offsets and reset values
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_COUNT  = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic        CTRL_RESET  = 1'b1;
   localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

   typedef enum logic [1:0] {
      ERR_ACTIVE  = 2'b00,
      ERR_PASSIVE = 2'b01,
      BUS_OFF     = 2'b11
   } fc_state_t;

   // Saturating counter add, used for both error counters
   function automatic logic [8:0] sat_add(input logic [8:0] a, input logic [8:0] b);
      logic [9:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[9] ? CNT_MAX : s[8:0];
   endfunction

endpackage

//--- recessive_run.sv
`timescale 1ns/10ps
module recessive_run
   import fc_pkg::*;
(
   input  wire logic mclk,         // System clock
   input  wire logic reset_n,      // Synchronous reset
   input  wire logic enable,       // Counting allowed (bus-off)
   input  wire logic bit_tick,     // One pulse per bit time
   input  wire logic rx_recessive, // Sampled bus level
   output logic      recovered     // Pulse after 128 runs
);

   logic [3:0] bit_cnt_reg;
   logic [3:0] bit_cnt_next;
   logic [6:0] occ_reg;
   logic [6:0] occ_next;
   logic       done_reg;
   logic       done_next;

   // A dominant bit restarts only the run, not the run tally
   always_comb begin
      bit_cnt_next = bit_cnt_reg;
      occ_next = occ_reg;
      done_next = 1'b0;
      if (!enable) begin
         bit_cnt_next = 4'h0;
         occ_next = 7'h00;
      end else if (bit_tick) begin
         if (!rx_recessive) begin
            bit_cnt_next = 4'h0;
         end else if (bit_cnt_reg == RUN_LAST) begin
            bit_cnt_next = 4'h0;
            if (occ_reg == OCC_LAST) begin
               occ_next = 7'h00;
               done_next = 1'b1;
            end else begin
               occ_next = occ_reg + 7'h01;
            end
         end else begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
         end
      end
   end

   // Register stage
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         bit_cnt_reg <= 4'h0;
         occ_reg <= 7'h00;
         done_reg <= 1'b0;
      end else begin
         bit_cnt_reg <= bit_cnt_next;
         occ_reg <= occ_next;
         done_reg <= done_next;
      end
   end

   assign recovered = done_reg;

endmodule

//--- status_byte_gen.sv
`timescale 1ns/10ps
module status_byte_gen
   import fc_pkg::*;
(
   input  wire logic       mclk,        // System clock
   input  wire logic       reset_n,     // Synchronous reset
   input  wire logic       warn_cond,   // A counter at or above 32
   input  wire logic       msg_ok,      // Successful message
   input  wire logic       sent_ok,     // Own frame sent
   input  wire logic [1:0] bus_mode,    // Current bus mode
   input  wire logic [2:0] reg_sel,     // Selector of data byte
   output logic [7:0]      status_byte, // First data byte
   output logic            warn_bit     // Error warning bit
);

   logic       rstd_reg;
   logic       rstd_next;
   logic       warn_reg;
   logic       warn_next;
   logic [7:0] byte_reg;
   logic [7:0] byte_next;

   // Warning is sticky until a good message; a new crossing wins
   always_comb begin
      rstd_next = sent_ok ? 1'b0 : rstd_reg;      // see [RULE17]
      warn_next = (msg_ok ? 1'b0 : warn_reg) | warn_cond; // see [RULE15]
      byte_next = {rstd_next, warn_next, bus_mode, SB_RSVD_VAL, reg_sel}; // see [RULE14] see [RULE16]
   end

   // Reset indicator starts high so the first frame announces it
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rstd_reg <= 1'b1;
         warn_reg <= 1'b0;
         byte_reg <= 8'h80;
      end else begin
         rstd_reg <= rstd_next;
         warn_reg <= warn_next;
         byte_reg <= byte_next;
      end
   end

   assign status_byte = byte_reg;
   assign warn_bit = warn_reg;

endmodule
